// >>> dv/pdt_timers_test.sv
// Self-checking bench for the prescaled dual 8-bit timer block.
// Assumes sys_clk is also the source clock; all inputs driven here.
`timescale 1ns/1ps
module pdt_timers_test;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sub_crystal_clock = 1'b0;
  logic sixteen_bit_timer_uf = 1'b0;
  logic pre_src_sel = 1'b0;
  logic pre_wr = 1'b0;
  logic [7:0] pre_wdata = 8'h00;
  logic [7:0] pre_count;
  logic t1_wr = 1'b0;
  logic [7:0] t1_wdata = 8'h00;
  logic [7:0] t1_count;
  logic t1_irq;
  logic [1:0] t2_src_sel = 2'h0;
  logic t2_wr_latch_only = 1'b0;
  logic t2_stop = 1'b0;
  logic t2_wr = 1'b0;
  logic [7:0] t2_wdata = 8'h00;
  logic [7:0] t2_count;
  logic t2_irq;
  logic tog_valid = 1'b0;
  logic tog_pol = 1'b0;
  logic tog_cfg_wr = 1'b0;
  logic toggle_output_pin_o;
  logic toggle_output_pin_oe;
  int errors = 0;
  int check_count = 0;
  int n;
  logic p;

  pdt_timers pdt_timers_i (.sys_clk, .arst_n, .sub_crystal_clock,
    .sixteen_bit_timer_uf, .pre_src_sel, .pre_wr, .pre_wdata, .pre_count,
    .t1_wr, .t1_wdata, .t1_count, .t1_irq, .t2_src_sel, .t2_wr_latch_only,
    .t2_stop, .t2_wr, .t2_wdata, .t2_count, .t2_irq, .tog_valid, .tog_pol,
    .tog_cfg_wr, .toggle_output_pin_o, .toggle_output_pin_oe);

  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic check8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check8

  task automatic check1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : check1

  task automatic check_int(input string nm, input int e, input int g);
    check_count++;
    if (g != e) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_int

  ////////////////////////////////////////////////////////////////////////
  // Bus helpers
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  // Write strobe: 0 prescaler, 1 first timer, 2 second timer
  task automatic wr(input int w, input logic [7:0] d);
    @(posedge sys_clk);
    pre_wr <= (w == 0);
    t1_wr <= (w == 1);
    t2_wr <= (w == 2);
    pre_wdata <= d;
    t1_wdata <= d;
    t2_wdata <= d;
    @(posedge sys_clk);
    pre_wr <= 1'b0;
    t1_wr <= 1'b0;
    t2_wr <= 1'b0;
    #1;
  endtask : wr

  // A wait that ran out counts a mismatch and ends the run
  task automatic timeout(input string nm);
    errors++;
    $display("CHECK FAILED %s expected event seen none", nm);
    results();
  endtask : timeout

  // Cycles until the next request pulse; bounded
  task automatic wait_irq(input logic sel, output int c);
    c = 0;
    do begin
      tick(1);
      c++;
      if (c > 2000) begin
        timeout("irq wait");
      end
    end while ((sel ? t2_irq : t1_irq) !== 1'b1);
  endtask : wait_irq

  task automatic toggle_cfg(input logic vld, input logic pol);
    @(posedge sys_clk);
    tog_valid <= vld;
    tog_pol <= pol;
    tog_cfg_wr <= 1'b1;
    @(posedge sys_clk);
    tog_cfg_wr <= 1'b0;
    #1;
  endtask : toggle_cfg

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check8("pre_count", 8'hFF, pre_count);
    check8("t1_count", 8'h01, t1_count);
    check8("t2_count", 8'hFF, t2_count);
    check1("pin", 1'b1, toggle_output_pin_o);
    $display("done reset");
  endtask : t_reset

  task automatic t_pre();
    logic [7:0] seq [5] = '{8'h02, 8'h01, 8'h00, 8'h03, 8'h02};
    logic [7:0] v;
    wr(0, 8'h03);
    check8("pre_count", 8'h03, pre_count);
    for (int i = 0; i < 5; i++) begin
      v = pre_count;
      n = 0;
      while (pre_count === v && n < 40) begin
        tick(1);
        n++;
      end
      if (pre_count === v) begin
        timeout("pre_count");
      end
      check8("pre_count", seq[i], pre_count);
      if (i > 0) begin
        check_int("pre step", 16, n);
      end
    end
    $display("done prescaler");
  endtask : t_pre

  task automatic t_t1();
    wr(1, 8'h02);
    check8("t1_count", 8'h02, t1_count);
    wait_irq(1'b0, n);
    wait_irq(1'b0, n);
    check_int("t1 period", 16 * 4 * 3, n);
    $display("done first timer");
  endtask : t_t1

  task automatic t_src();
    int per [3] = '{32, 512, 128};
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      t2_src_sel <= s[1:0];
      wr(2, 8'h01);
      wait_irq(1'b1, n);
      wait_irq(1'b1, n);
      check_int("t2 period", per[s], n);
      check8("t2 reload", 8'h01, t2_count);
    end
    @(posedge sys_clk);
    t2_src_sel <= 2'h3;
    wr(2, 8'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      sixteen_bit_timer_uf <= 1'b1;
      @(posedge sys_clk);
      sixteen_bit_timer_uf <= 1'b0;
      #1;
      check1("t2_irq", k[0], t2_irq);
      check8("t2_count", k ? 8'h01 : 8'h00, t2_count);
    end
    $display("done sources");
  endtask : t_src

  task automatic t_stop();
    @(posedge sys_clk);
    t2_src_sel <= 2'h0;
    t2_stop <= 1'b1;
    wr(2, 8'h00);
    check8("t2_count", 8'h00, t2_count);
    @(posedge sys_clk);
    t2_wr_latch_only <= 1'b1;
    wr(2, 8'h05);
    check8("t2_count", 8'h00, t2_count);
    tick(40);
    check8("t2 held", 8'h00, t2_count);
    @(posedge sys_clk);
    t2_stop <= 1'b0;
    t2_wr_latch_only <= 1'b0;
    wait_irq(1'b1, n);
    check8("t2 reload", 8'h05, t2_count);
    $display("done stop");
  endtask : t_stop

  task automatic t_toggle();
    wr(2, 8'h00);
    toggle_cfg(1'b1, 1'b1);
    check1("pin", 1'b0, toggle_output_pin_o);
    check1("pin_oe", 1'b1, toggle_output_pin_oe);
    for (int i = 0; i < 3; i++) begin
      p = toggle_output_pin_o;
      wait_irq(1'b1, n);
      check1("pin", ~p, toggle_output_pin_o);
    end
    toggle_cfg(1'b1, 1'b0);
    check1("pin", 1'b1, toggle_output_pin_o);
    toggle_cfg(1'b0, 1'b0);
    wait_irq(1'b1, n);
    wait_irq(1'b1, n);
    check1("pin", 1'b1, toggle_output_pin_o);
    check1("pin_oe", 1'b0, toggle_output_pin_oe);
    $display("done toggle");
  endtask : t_toggle

  task automatic t_sub();
    @(posedge sys_clk);
    pre_src_sel <= 1'b1;
    wr(0, 8'h10);
    tick(100);
    check8("pre_count", 8'h10, pre_count);
    repeat (3) begin
      @(posedge sys_clk);
      sub_crystal_clock <= 1'b1;
      repeat (8) @(posedge sys_clk);
      sub_crystal_clock <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    tick(4);
    check8("pre_count", 8'h0D, pre_count);
    $display("done sub clock");
  endtask : t_sub

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    tick(1);
    t_reset();
    t_pre();
    t_t1();
    t_src();
    t_stop();
    t_toggle();
    t_sub();
    results();
  end
endmodule : pdt_timers_test

// >>> include/pdt_cnt_if.sv
// Interface joining the control logic to one reloadable down counter.
// Assumes the counter and its controller share sys_clk.
`timescale 1ns/1ps
interface pdt_cnt_if;
  logic count_en;
  logic wr_both;
  logic wr_latch;
  logic [7:0] wdata;
  logic [7:0] count;
  logic [7:0] latch;
  logic underflow;

  // Controller side
  modport ctl (
    output count_en, wr_both, wr_latch, wdata,
    input count, latch, underflow
  );
  // Counter side
  modport cnt (
    input count_en, wr_both, wr_latch, wdata,
    output count, latch, underflow
  );
endinterface : pdt_cnt_if

// >>> include/pdt_pkg.sv
// Package for the prescaled dual 8-bit timer block.
// Assumes one 100 MHz system clock that also serves as the source clock.
package pdt_pkg;

  // Counter width shared by the prescaler and both timers
  localparam int CNT_W = 8;

  // Values after reset
  localparam logic [7:0] PRE_RST = 8'hFF;
  localparam logic [7:0] T1_RST = 8'h01;
  localparam logic [7:0] T2_RST = 8'hFF;

  // Source clock divisions, in source clock cycles
  localparam int DIV_LO = 16;
  localparam int DIV_HI = 256;
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_LO_MASK = 8'h0F;
  localparam logic [7:0] DIV_HI_MASK = 8'hFF;

  // Second timer count source selection
  typedef enum logic [1:0] {
    PDT_SRC_DIV16 = 2'h0,
    PDT_SRC_DIV256 = 2'h1,
    PDT_SRC_PRE = 2'h2,
    PDT_SRC_WIDE = 2'h3
  } pdt_t2_src_t;

  // Prescaler source selection
  localparam logic PRE_SRC_DIV16 = 1'b0;
  localparam logic PRE_SRC_SUB = 1'b1;

endpackage : pdt_pkg

// >>> rtl/pdt_down_counter.sv
// Reloadable 8-bit down counter with its own latch.
// Assumes count_en is a one-cycle enable pulse on sys_clk.
`timescale 1ns/1ps
module pdt_down_counter #(
  parameter logic [7:0] RST_VAL = 8'hFF
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  pdt_cnt_if.cnt bus // Control and status of this counter
);

  ////////////////////////////////////////////////////////////////////////
  // Underflow is the count pulse that finds the counter at zero; a
  // write of both latch and count in the same cycle takes priority and suppresses it
  assign bus.underflow = bus.count_en && (bus.count == 8'h00)
                         && !bus.wr_both;

  // Latch update on any write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.latch <= RST_VAL;
    end else if (bus.wr_both || bus.wr_latch) begin
      bus.latch <= bus.wdata;
    end
  end

  // Running count: load, reload or decrement
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.count <= RST_VAL;
    end else if (bus.wr_both) begin
      bus.count <= bus.wdata;
    end else if (bus.underflow) begin
      bus.count <= bus.latch;
    end else if (bus.count_en) begin
      bus.count <= bus.count - 8'h01;
    end
  end

endmodule : pdt_down_counter

// >>> rtl/pdt_src_div.sv
// Free-running divider of the system source clock.
// Assumes sys_clk is the source clock; gives /16 and /256 enable pulses.
`timescale 1ns/1ps
module pdt_src_div (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  output logic div16_pulse, // One cycle in 16
  output logic div256_pulse // One cycle in 256
);

  logic [pdt_pkg::DIV_W-1:0] div_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Free-running count, never stopped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Pulses from the count, registered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div16_pulse <= 1'b0;
      div256_pulse <= 1'b0;
    end else begin
      div16_pulse <= (div_cnt & pdt_pkg::DIV_LO_MASK)
                     == pdt_pkg::DIV_LO_MASK;
      div256_pulse <= div_cnt == pdt_pkg::DIV_HI_MASK;
    end
  end

endmodule : pdt_src_div

// >>> rtl/pdt_timers.sv
// Shared prescaler with two 8-bit down-counting timers.
// Assumes all inputs are synchronous to sys_clk, writes are one-cycle
// strobes, and the sub crystal clock is slow against sys_clk.
//
// Notes on behaviour
// - Divide by latch value plus one
// - Decrement per count; underflow after zero
// - Underflow reloads from latch, keeps counting
// - Each timer underflow raises its interrupt request
// - Prescaler counts source/16 or sub crystal
// - Prescaler write loads latch and count
// - Prescaler read returns live count
// - Prescaler resets to all ones
// - Prescaler never halts
// - First timer counts prescaler output only
// - First timer write loads latch and count
// - First timer resets to one; reads count
// - First timer cannot be stopped
// - Second timer source: /16, /256, prescaler, wide
// - Write control picks both or latch only
// - Second timer read returns live count
// - Second timer resets to all ones
// - Stop bit one holds second timer
// - Valid bit lets underflow invert pin
// - Polarity zero starts high, one low
`timescale 1ns/1ps
module pdt_timers (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic sub_crystal_clock, // Slow crystal clock, sampled
  input wire logic sixteen_bit_timer_uf, // Wide timer underflow pulse
  input wire logic pre_src_sel, // Prescaler source select
  input wire logic pre_wr, // Prescaler write strobe
  input wire logic [7:0] pre_wdata, // Prescaler write data
  output logic [7:0] pre_count, // Prescaler live count
  input wire logic t1_wr, // First timer write strobe
  input wire logic [7:0] t1_wdata, // First timer write data
  output logic [7:0] t1_count, // First timer live count
  output logic t1_irq, // First timer request pulse
  input wire logic [1:0] t2_src_sel, // Second timer source select
  input wire logic t2_wr_latch_only, // Write control: latch only
  input wire logic t2_stop, // Second timer count stop
  input wire logic t2_wr, // Second timer write strobe
  input wire logic [7:0] t2_wdata, // Second timer write data
  output logic [7:0] t2_count, // Second timer live count
  output logic t2_irq, // Second timer request pulse
  input wire logic tog_valid, // Toggle output valid
  input wire logic tog_pol, // Toggle polarity switch
  input wire logic tog_cfg_wr, // Strobe: valid or polarity written
  output logic toggle_output_pin_o, // Toggle pin level
  output logic toggle_output_pin_oe // Toggle pin drive enable
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic div16_pulse;
  logic div256_pulse;
  logic sub_q;
  logic sub_q2;
  logic sub_pulse;
  logic pre_src_pulse;
  logic t2_src_pulse;
  logic toggle;
  pdt_pkg::pdt_t2_src_t t2_src;

  pdt_cnt_if pre_if ();
  pdt_cnt_if t1_if ();
  pdt_cnt_if t2_if ();

  ////////////////////////////////////////////////////////////////////////
  // Source clock division

  pdt_src_div u_src_div (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .div16_pulse(div16_pulse),
    .div256_pulse(div256_pulse)
  );

  // Sub crystal edge detect; input taken as synchronous
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sub_q <= 1'b0;
      sub_q2 <= 1'b0;
    end else begin
      sub_q <= sub_crystal_clock;
      sub_q2 <= sub_q;
    end
  end

  // One pulse per rising crystal edge
  assign sub_pulse = sub_q && !sub_q2;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler

  assign pre_src_pulse = (pre_src_sel == pdt_pkg::PRE_SRC_SUB) ?
                         sub_pulse : div16_pulse;

  assign pre_if.count_en = pre_src_pulse;
  assign pre_if.wr_both = pre_wr;
  assign pre_if.wr_latch = 1'b0;
  assign pre_if.wdata = pre_wdata;

  pdt_down_counter #(
    .RST_VAL(pdt_pkg::PRE_RST)
  ) u_pre (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(pre_if)
  );

  assign pre_count = pre_if.count;

  ////////////////////////////////////////////////////////////////////////
  // First timer

  assign t1_if.count_en = pre_if.underflow;
  assign t1_if.wr_both = t1_wr;
  assign t1_if.wr_latch = 1'b0;
  assign t1_if.wdata = t1_wdata;

  pdt_down_counter #(
    .RST_VAL(pdt_pkg::T1_RST)
  ) u_t1 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(t1_if)
  );

  assign t1_count = t1_if.count;

  ////////////////////////////////////////////////////////////////////////
  // Second timer

  assign t2_src = pdt_pkg::pdt_t2_src_t'(t2_src_sel);

  always_comb begin
    unique case (t2_src)
      pdt_pkg::PDT_SRC_DIV16: t2_src_pulse = div16_pulse;
      pdt_pkg::PDT_SRC_DIV256: t2_src_pulse = div256_pulse;
      pdt_pkg::PDT_SRC_PRE: t2_src_pulse = pre_if.underflow;
      pdt_pkg::PDT_SRC_WIDE: t2_src_pulse = sixteen_bit_timer_uf;
    endcase
  end

  assign t2_if.count_en = t2_src_pulse && !t2_stop;
  assign t2_if.wr_both = t2_wr && !t2_wr_latch_only;
  assign t2_if.wr_latch = t2_wr && t2_wr_latch_only;
  assign t2_if.wdata = t2_wdata;

  pdt_down_counter #(
    .RST_VAL(pdt_pkg::T2_RST)
  ) u_t2 (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .bus(t2_if)
  );

  assign t2_count = t2_if.count;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      t1_irq <= 1'b0;
      t2_irq <= 1'b0;
    end else begin
      t1_irq <= t1_if.underflow;
      t2_irq <= t2_if.underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Toggle output

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      toggle <= 1'b1;
    end else if (tog_cfg_wr) begin
      toggle <= !tog_pol;
    end else if (tog_valid && t2_if.underflow) begin
      toggle <= !toggle;
    end
  end

  // Pin level and drive enable
  assign toggle_output_pin_o = toggle;
  assign toggle_output_pin_oe = tog_valid;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  // Sixteen-cycle spacing of source pulses
  sequence s_div16_gap;
    div16_pulse ##16 div16_pulse;
  endsequence

  // Underflow followed by reload one cycle later
  sequence s_pre_reload;
    pre_if.underflow ##1 (pre_count == $past(pre_if.latch));
  endsequence

  property p_div16;
    @(posedge sys_clk) disable iff (!arst_n)
    div16_pulse |-> s_div16_gap;
  endproperty
  a_div16: assert property (p_div16)
    else $error("source /16 pulse spacing wrong");

  property p_pre_reload;
    @(posedge sys_clk) disable iff (!arst_n)
    pre_if.underflow |-> s_pre_reload;
  endproperty
  a_pre_reload: assert property (p_pre_reload)
    else $error("prescaler did not reload from latch");

  // Reaching zero is a plain decrement; the next timer must not move
  property p_pre_uf_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    pre_if.count_en && !pre_wr && !t1_wr && pre_count == 8'h01
      |=> pre_count == 8'h00 && $stable(t1_count);
  endproperty
  a_pre_uf_zero: assert property (p_pre_uf_zero)
    else $error("prescaler underflowed on reaching zero");

  property p_t1_dec;
    @(posedge sys_clk) disable iff (!arst_n)
    t1_if.count_en && !t1_wr && t1_count != 8'h00
      |=> t1_count == $past(t1_count) - 8'h01;
  endproperty
  a_t1_dec: assert property (p_t1_dec)
    else $error("first timer did not decrement");

  property p_t1_only_pre;
    @(posedge sys_clk) disable iff (!arst_n)
    !pre_if.underflow && !t1_wr |=> $stable(t1_count);
  endproperty
  a_t1_only_pre: assert property (p_t1_only_pre)
    else $error("first timer moved without prescaler output");

  property p_t1_wr;
    @(posedge sys_clk) disable iff (!arst_n)
    t1_wr |=> t1_count == $past(t1_wdata)
      && t1_if.latch == $past(t1_wdata);
  endproperty
  a_t1_wr: assert property (p_t1_wr)
    else $error("first timer write did not load both");

  property p_pre_wr;
    @(posedge sys_clk) disable iff (!arst_n)
    pre_wr |=> pre_count == $past(pre_wdata)
      && pre_if.latch == $past(pre_wdata);
  endproperty
  a_pre_wr: assert property (p_pre_wr)
    else $error("prescaler write did not load both");

  property p_t2_latch_only;
    @(posedge sys_clk) disable iff (!arst_n)
    t2_wr && t2_wr_latch_only && !t2_if.count_en
      |=> t2_if.latch == $past(t2_wdata) && $stable(t2_count);
  endproperty
  a_t2_latch_only: assert property (p_t2_latch_only)
    else $error("latch-only write touched the count");

  property p_t2_stop;
    @(posedge sys_clk) disable iff (!arst_n)
    t2_stop && !t2_wr |=> $stable(t2_count);
  endproperty
  a_t2_stop: assert property (p_t2_stop)
    else $error("second timer moved while stopped");

  property p_t2_irq;
    @(posedge sys_clk) disable iff (!arst_n)
    t2_if.underflow |=> t2_irq && t2_count == $past(t2_if.latch);
  endproperty
  a_t2_irq: assert property (p_t2_irq)
    else $error("second timer request missing at underflow");

  property p_toggle;
    @(posedge sys_clk) disable iff (!arst_n)
    tog_valid && t2_if.underflow && !tog_cfg_wr
      |=> toggle_output_pin_o != $past(toggle_output_pin_o);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle pin did not invert at underflow");

  property p_tog_start;
    @(posedge sys_clk) disable iff (!arst_n)
    tog_cfg_wr |=> toggle_output_pin_o == !$past(tog_pol);
  endproperty
  a_tog_start: assert property (p_tog_start)
    else $error("toggle start level wrong");

  property p_t1_irq;
    @(posedge sys_clk) disable iff (!arst_n)
    t1_if.underflow |=> t1_irq && t1_count == $past(t1_if.latch);
  endproperty
  a_t1_irq: assert property (p_t1_irq)
    else $error("first timer request missing at underflow");

  property p_pre_run;
    @(posedge sys_clk) disable iff (!arst_n)
    pre_src_pulse && !pre_wr && pre_count != 8'h00
      |=> pre_count == $past(pre_count) - 8'h01;
  endproperty
  a_pre_run: assert property (p_pre_run)
    else $error("prescaler missed a count pulse");

  property p_t2_wide;
    @(posedge sys_clk) disable iff (!arst_n)
    t2_src == pdt_pkg::PDT_SRC_WIDE && sixteen_bit_timer_uf && !t2_stop
      && !t2_wr && t2_count != 8'h00
      |=> t2_count == $past(t2_count) - 8'h01;
  endproperty
  a_t2_wide: assert property (p_t2_wide)
    else $error("second timer ignored wide timer underflow");

  property p_tog_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    !tog_cfg_wr && !(tog_valid && t2_if.underflow)
      |=> $stable(toggle_output_pin_o);
  endproperty
  a_tog_hold: assert property (p_tog_hold)
    else $error("toggle pin moved without an event");

endmodule : pdt_timers
